// *** src/ppf_core.sv ***
// peripheral_proc channel function instructions and major-cycle timing sequencer
// Behaviour
// - processors other than 0 hang after deadstart
// - deactivation then resumes at the address held in location 0000 plus one
// - accumulator function sends low 12 bits
// - active channel without bit 5 stalls function
// - accumulator function skip suppresses transfer, p plus 1
// - operand function sends second word as code
// - operand function skip suppresses transfer, p plus 2
// - times counted in 500 ns major cycles
// - short ops one, long jump three, return four
// - relocation load three, store four cycles
// - all exchange jump variants take two cycles
// - direct ops two, replace four, plus-minus five
// - indirect ops three, replace five, plus-minus six
// - indexed ops four, replace six, plus-minus seven
// - central_store word read twelve, write six
// - block central_store transfers depend on word count
// - channel test and flag jumps take two
// - channel word input two, block input variable
// - block read seven plus five per word
// - block channel five plus one or two each
// - output, activate, deactivate, functions take two
`timescale 1ns/1ps
`default_nettype none
`include "ppf_cfg.svh"

module ppf_core #(
  parameter int PP_INDEX = 1,
  parameter int MAJOR_CLKS = `PPF_MAJOR_CLKS
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic instr_valid_in,
  input wire logic [5:0] opcode_in,
  input wire logic [5:0] d_in,
  input wire logic [11:0] m_in,
  input wire logic [11:0] acc_in,
  input wire logic [11:0] p_in,
  input wire logic [11:0] words_in,
  input wire logic [11:0] loc0_in,
  input wire logic chan_active_in,
  input wire logic conflict_in,
  input wire logic slot_shared_in,
  output logic ready_out,
  output logic busy_out,
  output logic hang_out,
  output logic done_out,
  output logic [11:0] p_out,
  output logic func_valid_out,
  output logic [11:0] func_word_out,
  output logic [4:0] func_chan_out
);

  // major cycles an opcode takes without conflicts
  function automatic logic [15:0] cycles_of(input logic [5:0] op, input logic [11:0] words,
                                            input logic shared);
    logic [15:0] w16;
    logic [15:0] res;
    w16 = {4'h0, words};
    res = `PPF_CYC_SHORT;
    case (op[5:3])
      `PPF_HI_JUMP: begin
        if (op == `PPF_OP_LONG_JUMP) begin
          res = `PPF_CYC_LONG_JUMP;
        end else if (op == `PPF_OP_RETURN_JUMP) begin
          res = `PPF_CYC_RETURN_JUMP;
        end
      end
      `PPF_HI_PAIR: begin
        if (op == `PPF_OP_LOAD_RELOC) begin
          res = `PPF_CYC_LOAD_RELOC;
        end else if (op == `PPF_OP_STORE_RELOC) begin
          res = `PPF_CYC_STORE_RELOC;
        end else if (op == `PPF_OP_EXCHANGE) begin
          res = `PPF_CYC_EXCHANGE;
        end else if (op[2:0] != `PPF_LO_PASS_27) begin
          res = `PPF_CYC_DIR;
        end
      end
      `PPF_HI_DIRECT: begin
        if (op[2:0] < `PPF_LO_REPLACE_ADD) res = `PPF_CYC_DIR;
        else if (op[2:0] == `PPF_LO_REPLACE_ADD) res = `PPF_CYC_DIR_RADD;
        else res = `PPF_CYC_DIR_RPM;
      end
      `PPF_HI_INDIRECT: begin
        if (op[2:0] < `PPF_LO_REPLACE_ADD) res = `PPF_CYC_IND;
        else if (op[2:0] == `PPF_LO_REPLACE_ADD) res = `PPF_CYC_IND_RADD;
        else res = `PPF_CYC_IND_RPM;
      end
      `PPF_HI_INDEXED: begin
        if (op[2:0] < `PPF_LO_REPLACE_ADD) res = `PPF_CYC_IDX;
        else if (op[2:0] == `PPF_LO_REPLACE_ADD) res = `PPF_CYC_IDX_RADD;
        else res = `PPF_CYC_IDX_RPM;
      end
      `PPF_HI_CENTRAL: begin
        case (op)
          `PPF_OP_CS_READ: res = `PPF_CYC_CS_READ;
          `PPF_OP_CS_WRITE: res = `PPF_CYC_CS_WRITE;
          `PPF_OP_CS_BLOCK_READ: res = `PPF_CYC_CS_RD_SETUP + w16 * `PPF_CYC_CS_PER_WORD;
          `PPF_OP_CS_BLOCK_WRITE: res = `PPF_CYC_CS_WR_SETUP + w16 * `PPF_CYC_CS_PER_WORD;
          default: res = `PPF_CYC_CHAN;
        endcase
      end
      `PPF_HI_CHANNEL: begin
        if (op == `PPF_OP_BLOCK_IN || op == `PPF_OP_BLOCK_OUT) begin
          res = `PPF_CYC_CH_SETUP
                + w16 * (shared ? `PPF_CYC_CH_WORD_SHARED : `PPF_CYC_CH_WORD);
        end else begin
          res = `PPF_CYC_CHAN;
        end
      end
      default: res = `PPF_CYC_SHORT;
    endcase
    return res;
  endfunction

  // instruction length in words, for the address advance
  function automatic logic [11:0] length_of(input logic [5:0] op);
    logic two;
    two = 1'b0;
    case (op[5:3])
      `PPF_HI_JUMP: two = (op == `PPF_OP_LONG_JUMP) || (op == `PPF_OP_RETURN_JUMP);
      `PPF_HI_PAIR: two = (op[2:0] < `PPF_LO_CHAN_TEST);
      `PPF_HI_INDEXED: two = 1'b1;
      `PPF_HI_CENTRAL: two = (op == `PPF_OP_CS_BLOCK_READ) || (op == `PPF_OP_CS_BLOCK_WRITE)
                             || (op[2:0] >= `PPF_LO_CHAN_TEST);
      `PPF_HI_CHANNEL: two = (op == `PPF_OP_BLOCK_IN) || (op == `PPF_OP_BLOCK_OUT)
                             || (op == `PPF_OP_FUNC_OPND);
      default: two = 1'b0;
    endcase
    return two ? `PPF_LEN_TWO : `PPF_LEN_ONE;
  endfunction

  // channel active comes from a pin; two flops before any use, third for the edge
  logic chan_act_m;
  logic chan_act_s;
  logic chan_act_d;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      chan_act_m <= 1'b0;
      chan_act_s <= 1'b0;
      chan_act_d <= 1'b0;
    end else begin
      chan_act_m <= chan_active_in;
      chan_act_s <= chan_act_m;
      chan_act_d <= chan_act_s;
    end
  end

  ppf_pkg::ppf_state_t state;
  ppf_pkg::ppf_state_t next_state;
  logic [15:0] remaining;
  logic [15:0] next_remaining;
  logic [15:0] phase;
  logic [15:0] next_phase;
  logic [11:0] p;
  logic [11:0] next_p;
  logic func_valid;
  logic next_func_valid;
  logic [11:0] func_word;
  logic [11:0] next_func_word;
  logic [4:0] func_chan;
  logic [4:0] next_func_chan;
  logic done;
  logic next_done;
  logic take;
  logic is_func;
  logic tick;
  logic deact;

  assign take = instr_valid_in && ready_out;
  assign is_func = (opcode_in == `PPF_OP_FUNC_ACC) || (opcode_in == `PPF_OP_FUNC_OPND);
  assign tick = (phase == 16'(MAJOR_CLKS - 1));
  assign deact = chan_act_d && !chan_act_s;

  always_comb begin
    next_state = state;
    next_remaining = remaining;
    next_phase = phase;
    next_p = p;
    next_func_valid = 1'b0;
    next_func_word = func_word;
    next_func_chan = func_chan;
    next_done = 1'b0;
    case (state)
      ppf_pkg::st_idle: begin
        if (take) begin
          next_p = p_in + length_of(opcode_in);
          next_phase = 16'h0000;
          next_remaining = cycles_of(opcode_in, words_in, slot_shared_in);
          if (is_func) begin
            // word is latched now so a stalled function sends what was issued
            next_func_word = (opcode_in == `PPF_OP_FUNC_ACC) ? acc_in : m_in;
            next_func_chan = d_in[`PPF_CHAN_MSB:0];
          end
          if (is_func && chan_act_s && !d_in[`PPF_D_NOHANG_BIT]) begin
            next_state = ppf_pkg::st_hang;
          end else begin
            next_state = ppf_pkg::st_exec;
            // skip form on an active channel sends nothing
            next_func_valid = is_func && !chan_act_s;
          end
        end
      end
      ppf_pkg::st_exec: begin
        if (tick) begin
          next_phase = 16'h0000;
          if (!conflict_in) begin
            if (remaining <= `PPF_CYC_SHORT) begin
              next_state = ppf_pkg::st_idle;
              next_done = 1'b1;
            end else begin
              next_remaining = remaining - `PPF_CYC_SHORT;
            end
          end
        end else begin
          next_phase = phase + 16'h0001;
        end
      end
      ppf_pkg::st_hang: begin
        if (!chan_act_s) begin
          next_func_valid = 1'b1;
          next_state = ppf_pkg::st_exec;
          next_remaining = `PPF_CYC_CHAN;
          next_phase = 16'h0000;
        end
      end
      ppf_pkg::st_boot: begin
        if (deact) begin
          next_p = loc0_in + `PPF_LOC0_ADVANCE;
          next_state = ppf_pkg::st_idle;
        end
      end
      default: next_state = ppf_pkg::st_idle;
    endcase
  end

  // deadstart is rst_in; non-zero processors wake up parked on channel input
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state <= (PP_INDEX != 0) ? ppf_pkg::st_boot : ppf_pkg::st_idle;
      remaining <= 16'h0000;
      phase <= 16'h0000;
      p <= 12'h000;
      func_valid <= 1'b0;
      func_word <= 12'h000;
      func_chan <= 5'h00;
      done <= 1'b0;
      ready_out <= (PP_INDEX == 0);
      busy_out <= (PP_INDEX != 0);
      hang_out <= (PP_INDEX != 0);
    end else begin
      state <= next_state;
      remaining <= next_remaining;
      phase <= next_phase;
      p <= next_p;
      func_valid <= next_func_valid;
      func_word <= next_func_word;
      func_chan <= next_func_chan;
      done <= next_done;
      ready_out <= (next_state == ppf_pkg::st_idle);
      busy_out <= (next_state != ppf_pkg::st_idle);
      hang_out <= (next_state == ppf_pkg::st_hang) || (next_state == ppf_pkg::st_boot);
    end
  end

  assign p_out = p;
  assign func_valid_out = func_valid;
  assign func_word_out = func_word;
  assign func_chan_out = func_chan;
  assign done_out = done;

  // helper for the timing check: clocks spent and whether a stall occurred
  logic [31:0] chk_clks;
  logic [15:0] chk_exp;
  logic chk_stalled;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      chk_clks <= 32'h0;
      chk_exp <= 16'h0;
      chk_stalled <= 1'b0;
    end else begin
      if (take) begin
        chk_clks <= 32'h0;
        chk_exp <= cycles_of(opcode_in, words_in, slot_shared_in);
        chk_stalled <= is_func && chan_act_s && !d_in[`PPF_D_NOHANG_BIT];
      end else if (state == ppf_pkg::st_exec) begin
        chk_clks <= chk_clks + 32'h1;
        if (tick && conflict_in) chk_stalled <= 1'b1;
      end
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  property p_boot_park;
    state == ppf_pkg::st_boot && !deact |=> hang_out && !ready_out && state == ppf_pkg::st_boot;
  endproperty
  a_boot_park: assert property (p_boot_park) else $error("parked processor left early");

  property p_boot_resume;
    state == ppf_pkg::st_boot && deact
      |=> p_out == $past(loc0_in) + `PPF_LOC0_ADVANCE ##0 ready_out;
  endproperty
  a_boot_resume: assert property (p_boot_resume) else $error("resume address wrong");

  property p_func_acc;
    take && opcode_in == `PPF_OP_FUNC_ACC && !chan_act_s
      |=> func_valid_out && func_word_out == $past(acc_in) ##1 !func_valid_out;
  endproperty
  a_func_acc: assert property (p_func_acc) else $error("accumulator function word wrong");

  property p_func_opnd;
    take && opcode_in == `PPF_OP_FUNC_OPND && !chan_act_s
      |=> func_valid_out && func_word_out == $past(m_in);
  endproperty
  a_func_opnd: assert property (p_func_opnd) else $error("operand function word wrong");

  property p_stall;
    state == ppf_pkg::st_hang && chan_act_s
      |=> state == ppf_pkg::st_hang && !func_valid_out && hang_out;
  endproperty
  a_stall: assert property (p_stall) else $error("function did not stall");

  property p_skip_acc;
    take && opcode_in == `PPF_OP_FUNC_ACC && chan_act_s && d_in[`PPF_D_NOHANG_BIT]
      |=> !func_valid_out && !hang_out && p_out == $past(p_in) + `PPF_LEN_ONE;
  endproperty
  a_skip_acc: assert property (p_skip_acc) else $error("accumulator skip wrong");

  property p_skip_opnd;
    take && opcode_in == `PPF_OP_FUNC_OPND && chan_act_s && d_in[`PPF_D_NOHANG_BIT]
      |=> !func_valid_out && !hang_out && p_out == $past(p_in) + `PPF_LEN_TWO;
  endproperty
  a_skip_opnd: assert property (p_skip_opnd) else $error("operand skip wrong");

  property p_exec_time;
    done_out && !chk_stalled |-> chk_clks == 32'(chk_exp) * 32'(MAJOR_CLKS);
  endproperty
  a_exec_time: assert property (p_exec_time) else $error("execution time off");

  property p_long_jump;
    take && opcode_in == `PPF_OP_LONG_JUMP |=> remaining == `PPF_CYC_LONG_JUMP;
  endproperty
  a_long_jump: assert property (p_long_jump) else $error("long jump count wrong");

  property p_cs_read;
    take && opcode_in == `PPF_OP_CS_READ |=> remaining == `PPF_CYC_CS_READ;
  endproperty
  a_cs_read: assert property (p_cs_read) else $error("central read count wrong");

  property p_conflict;
    state == ppf_pkg::st_exec && tick && conflict_in
      |=> state == ppf_pkg::st_exec && remaining == $past(remaining);
  endproperty
  a_conflict: assert property (p_conflict) else $error("stall cycle lost");

  c_func_sent: cover property (take && is_func && !chan_act_s ##1 func_valid_out);
  c_func_hang: cover property (state == ppf_pkg::st_hang ##[1:50] func_valid_out);
  c_boot_resume: cover property (state == ppf_pkg::st_boot && deact);
  c_stall: cover property (state == ppf_pkg::st_exec && tick && conflict_in);

endmodule

`default_nettype wire

// *** src/ppf_cfg.svh ***
// timing counts, opcodes and field positions of the function and timing sequencer
`ifndef PPF_CFG_SVH
`define PPF_CFG_SVH
`define PPF_CLK_NS 4
`define PPF_MAJOR_NS 500
`define PPF_MAJOR_CLKS (`PPF_MAJOR_NS / `PPF_CLK_NS)
`define PPF_OP_LONG_JUMP 6'h01
`define PPF_OP_RETURN_JUMP 6'h02
`define PPF_OP_LOAD_RELOC 6'h14
`define PPF_OP_STORE_RELOC 6'h15
`define PPF_OP_EXCHANGE 6'h16
`define PPF_OP_CS_READ 6'h30
`define PPF_OP_CS_BLOCK_READ 6'h31
`define PPF_OP_CS_WRITE 6'h32
`define PPF_OP_CS_BLOCK_WRITE 6'h33
`define PPF_OP_CHAN_IN 6'h38
`define PPF_OP_BLOCK_IN 6'h39
`define PPF_OP_BLOCK_OUT 6'h3b
`define PPF_OP_FUNC_ACC 6'h3e
`define PPF_OP_FUNC_OPND 6'h3f
`define PPF_HI_JUMP 3'h0
`define PPF_HI_SHORT 3'h1
`define PPF_HI_PAIR 3'h2
`define PPF_HI_DIRECT 3'h3
`define PPF_HI_INDIRECT 3'h4
`define PPF_HI_INDEXED 3'h5
`define PPF_HI_CENTRAL 3'h6
`define PPF_HI_CHANNEL 3'h7
`define PPF_LO_REPLACE_ADD 3'h5
`define PPF_LO_PASS_27 3'h7
`define PPF_LO_CHAN_TEST 3'h4
`define PPF_D_NOHANG_BIT 5
`define PPF_CHAN_MSB 4
`define PPF_LEN_ONE 12'h001
`define PPF_LEN_TWO 12'h002
`define PPF_LOC0_ADVANCE 12'h001
`define PPF_CYC_SHORT 16'h0001
`define PPF_CYC_LONG_JUMP 16'h0003
`define PPF_CYC_RETURN_JUMP 16'h0004
`define PPF_CYC_LOAD_RELOC 16'h0003
`define PPF_CYC_STORE_RELOC 16'h0004
`define PPF_CYC_EXCHANGE 16'h0002
`define PPF_CYC_DIR 16'h0002
`define PPF_CYC_DIR_RADD 16'h0004
`define PPF_CYC_DIR_RPM 16'h0005
`define PPF_CYC_IND 16'h0003
`define PPF_CYC_IND_RADD 16'h0005
`define PPF_CYC_IND_RPM 16'h0006
`define PPF_CYC_IDX 16'h0004
`define PPF_CYC_IDX_RADD 16'h0006
`define PPF_CYC_IDX_RPM 16'h0007
`define PPF_CYC_CS_READ 16'h000c
`define PPF_CYC_CS_WRITE 16'h0006
`define PPF_CYC_CS_RD_SETUP 16'h0007
`define PPF_CYC_CS_WR_SETUP 16'h0006
`define PPF_CYC_CS_PER_WORD 16'h0005
`define PPF_CYC_CH_SETUP 16'h0005
`define PPF_CYC_CH_WORD 16'h0001
`define PPF_CYC_CH_WORD_SHARED 16'h0002
`define PPF_CYC_CHAN 16'h0002
`endif

// *** src/ppf_pkg.sv ***
// types of the function and timing sequencer
package ppf_pkg;
  typedef enum logic [1:0] {st_idle, st_exec, st_hang, st_boot} ppf_state_t;
endpackage

// *** verif/ppf_chan_model.sv ***
// channel equipment model standing on the far side of the function sequencer
`timescale 1ns/1ps
`default_nettype none
module ppf_chan_model (
  input wire logic clk_sys_in,
  input wire logic go_active_in,
  input wire logic func_valid_in,
  input wire logic [11:0] func_word_in,
  input wire logic [4:0] func_chan_in,
  output wire logic chan_active_out,
  output logic [11:0] seen_word_out,
  output logic [4:0] seen_chan_out,
  output wire logic [7:0] seen_count_out
);
  logic [7:0] count = 8'h00;
  // pin moves off the clock grid; its drop frees a hung function
  assign #0.7 chan_active_out = go_active_in;
  assign seen_count_out = count;
  // words taken in the cycle they come, so the channel is empty before a drop
  always @(posedge clk_sys_in) begin
    if (func_valid_in === 1'b1) begin
      seen_word_out <= func_word_in;
      seen_chan_out <= func_chan_in;
      count <= count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** verif/ppf_core_tb_top.sv ***
// self-checking bench of the function and timing sequencer
`timescale 1ns/1ps
`default_nettype none
module ppf_core_tb_top;
  localparam int M = 4;
  localparam logic [5:0] CORNER [19] = '{6'h01, 6'h02, 6'h14, 6'h15, 6'h16, 6'h1d, 6'h1f,
    6'h25, 6'h27, 6'h2d, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h33, 6'h39, 6'h3b, 6'h3e, 6'h3f};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [5:0] opcode = 6'h00;
  logic [5:0] d_fld = 6'h00;
  logic [11:0] m_w = 12'h000;
  logic [11:0] acc_w = 12'h000;
  logic [11:0] p_w = 12'h000;
  logic [11:0] words = 12'h001;
  logic [11:0] loc0 = 12'h000;
  logic conflict = 1'b0;
  logic shared = 1'b0;
  logic go_active = 1'b1;
  wire logic chan_active;
  logic ready, busy, hang, done, func_valid, pk_ready, pk_hang;
  logic [11:0] p_o, func_word, pk_p, seen_word;
  logic [4:0] func_chan, seen_chan;
  logic [7:0] seen_count;
  logic [31:0] seed = 32'h7af60a16;
  int failures = 0;
  int tests_run = 0;

  ppf_core #(.PP_INDEX(0), .MAJOR_CLKS(M)) i_ppf_core (
    .clk_sys_in(clk_sys), .rst_in(rst), .instr_valid_in(instr_valid), .opcode_in(opcode),
    .d_in(d_fld), .m_in(m_w), .acc_in(acc_w), .p_in(p_w), .words_in(words), .loc0_in(loc0),
    .chan_active_in(chan_active), .conflict_in(conflict), .slot_shared_in(shared),
    .ready_out(ready), .busy_out(busy), .hang_out(hang), .done_out(done), .p_out(p_o),
    .func_valid_out(func_valid), .func_word_out(func_word), .func_chan_out(func_chan));
  ppf_core #(.PP_INDEX(1), .MAJOR_CLKS(M)) i_ppf_core_parked (
    .clk_sys_in(clk_sys), .rst_in(rst), .instr_valid_in(instr_valid), .opcode_in(opcode),
    .d_in(d_fld), .m_in(m_w), .acc_in(acc_w), .p_in(p_w), .words_in(words), .loc0_in(loc0),
    .chan_active_in(chan_active), .conflict_in(conflict), .slot_shared_in(shared),
    .ready_out(pk_ready), .busy_out(), .hang_out(pk_hang), .done_out(), .p_out(pk_p),
    .func_valid_out(), .func_word_out(), .func_chan_out());
  ppf_chan_model i_ppf_chan_model (.clk_sys_in(clk_sys), .go_active_in(go_active),
    .func_valid_in(func_valid), .func_word_in(func_word), .func_chan_in(func_chan),
    .chan_active_out(chan_active), .seen_word_out(seen_word), .seen_chan_out(seen_chan),
    .seen_count_out(seen_count));

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // major cycles per opcode with no conflict
  function automatic int exp_cyc(input logic [5:0] op, input logic [11:0] w, input logic sh);
    int lo;
    lo = int'(op[2:0]);
    case (op[5:3])
      3'h0: return (lo == 1) ? 3 : (lo == 2) ? 4 : 1;
      3'h1: return 1;
      3'h2: return (lo < 4 || lo == 6) ? 2 : (lo == 4) ? 3 : (lo == 5) ? 4 : 1;
      3'h3: return (lo < 5) ? 2 : (lo == 5) ? 4 : 5;
      3'h4: return (lo < 5) ? 3 : (lo == 5) ? 5 : 6;
      3'h5: return (lo < 5) ? 4 : (lo == 5) ? 6 : 7;
      3'h6: return (lo == 0) ? 12 : (lo == 2) ? 6 : (lo > 3) ? 2 :
                   (lo == 1 ? 7 : 6) + 5 * int'(w);
      default: return (lo == 1 || lo == 3) ? 5 + int'(w) * (sh ? 2 : 1) : 2;
    endcase
  endfunction

  // one request; counts edges from the taking edge to the done pulse
  task automatic issue(input logic [5:0] op, input logic [5:0] dd, input int conf_at,
                       input int drop_at, output int cyc, output int nfv,
                       output logic [11:0] p1);
    @(posedge clk_sys);
    #1;
    instr_valid = 1'b1;
    opcode = op;
    d_fld = dd;
    @(posedge clk_sys);
    #1;
    instr_valid = 1'b0;
    cyc = 0;
    // an idle-channel function pulse stands in the cycle right after the take
    nfv = (func_valid === 1'b1) ? 1 : 0;
    p1 = p_o;
    conflict = (conf_at == 1);
    while (cyc < 400) begin
      @(posedge clk_sys);
      #1;
      cyc++;
      if (func_valid === 1'b1) nfv++;
      if (cyc == drop_at) begin
        chk("hang flag", 16'h0001, {15'h0000, hang});
        chk("busy while hung", 16'h0001, {15'h0000, busy});
        chk("early function", 16'h0000, 16'(nfv));
      end
      if (done === 1'b1) break;
      conflict = (cyc + 1 == conf_at);
      if (cyc == drop_at) go_active = 1'b0;
    end
    #1;
  endtask

  task automatic run_case(input logic [5:0] op, input logic [5:0] dd);
    int cyc, nfv;
    logic [11:0] p1;
    logic [7:0] sc0;
    sc0 = seen_count;
    issue(op, dd, 0, 0, cyc, nfv, p1);
    chk("cycles", 16'(exp_cyc(op, words, shared) * M), 16'(cyc));
    chk("far side count", 16'(op == 6'h3e || op == 6'h3f), {8'h00, 8'(seen_count - sc0)});
    if (op == 6'h3e || op == 6'h3f) begin
      chk("func count", 16'h0001, 16'(nfv));
      chk("func word", {4'h0, op[0] ? m_w : acc_w}, {4'h0, func_word});
      chk("func chan", {11'h000, dd[4:0]}, {11'h000, func_chan});
    end else begin
      chk("func count", 16'h0000, 16'(nfv));
    end
    if (op == 6'h3e) chk("next p", {4'h0, p_w + 12'h001}, {4'h0, p1});
  endtask

  initial begin
    int cyc, nfv;
    logic [11:0] p1;
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    @(posedge clk_sys);
    #1;
    chk("pp0 ready", 16'h0001, {15'h0000, ready});
    chk("pp0 hang", 16'h0000, {15'h0000, hang});
    chk("parked hang", 16'h0001, {15'h0000, pk_hang});
    chk("parked ready", 16'h0000, {15'h0000, pk_ready});
    loc0 = 12'h5a3;
    go_active = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk("resume p", 16'h05a4, {4'h0, pk_p});
    chk("resume ready", 16'h0001, {15'h0000, pk_ready});
    $display("test boot done");
    // skip forms on an active channel, program address wraps past the top
    p_w = 12'hffe;
    for (int k = 0; k < 2; k++) begin
      go_active = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      issue(6'h3e + 6'(k), 6'h23, 0, 0, cyc, nfv, p1);
      chk("skip cycles", 16'(2 * M), 16'(cyc));
      chk("skip func", 16'h0000, 16'(nfv));
      chk("skip p", {4'h0, p_w + 12'h001 + 12'(k)}, {4'h0, p1});
    end
    $display("test skip done");
    acc_w = 12'ha5c;
    m_w = 12'h3c1;
    for (int k = 0; k < 2; k++) begin
      go_active = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      issue(6'h3e + 6'(k), 6'h05 + 6'(k), 0, 6, cyc, nfv, p1);
      chk("release time", 16'h0001, {15'h0000, cyc >= 9 + 2 * M && cyc <= 11 + 2 * M});
      chk("late func", 16'h0001, 16'(nfv));
      chk("sent word", k ? 16'h03c1 : 16'h0a5c, {4'h0, seen_word});
      chk("sent chan", 16'h0005 + 16'(k), {11'h000, seen_chan});
    end
    $display("test hang done");
    issue(6'h18, 6'h00, M, 0, cyc, nfv, p1);
    chk("stretched cycles", 16'(3 * M), 16'(cyc));
    $display("test conflict done");
    for (int i = 0; i < 19; i++) begin
      words = 12'(i % 4 + 1);
      shared = 1'(i % 2);
      run_case(CORNER[i], 6'h0a);
    end
    $display("test corner done");
    for (int i = 0; i < 40; i++) begin
      seed = lfsr_next(seed);
      acc_w = seed[11:0];
      m_w = seed[23:12];
      p_w = seed[31:20];
      words = 12'(seed[1:0]) + 12'h001;
      shared = seed[2];
      run_case(seed[9:4], seed[31:26]);
    end
    $display("test random done");
    give_verdict();
  end

  // run needs a few thousand cycles; twenty thousand means a hang
  initial begin
    #80000;
    failures++;
    $display("BAD watchdog expected finish seen hang");
    give_verdict();
  end
endmodule
`default_nettype wire
